/* rtl/ath_cfg.svh */
// offsets, field positions, reset values and sizes of the transmit header insertion block
// What this block does
// - 8-Kbyte buffer, partitions written by either port
// - device prepends header when insertion enabled
// - four header registers per buffer, reset zero
// - insert headers only for payload packet types
// - insertable tcodes are 0,1,6,7,9
// - quadlet packet: info, two address quadlets, data
// - quadlet data only for writes and read responses
// - speed 00/01/10 valid, 11 undefined
// - destination id is bus and node number
`ifndef ATH_CFG_SVH
`define ATH_CFG_SVH

`define ATH_DB_BYTES 8192
`define ATH_DB_WORDS (`ATH_DB_BYTES / 4)
`define ATH_NUM_BUF 8

// micro host port register selects within one buffer
`define ATH_SEL_ACC0 3'h0
`define ATH_SEL_ACC1 3'h1
`define ATH_SEL_H0 3'h2
`define ATH_SEL_H3 3'h5
`define ATH_SEL_CTRL 3'h6
`define ATH_SEL_STAT 3'h7

`define ATH_HDR_RESET 32'h00000000
`define ATH_CTRL_INS_BIT 0
`define ATH_STAT_DROP_BIT 31

// fields of the first header quadlet
`define ATH_SPD_LSB 16
`define ATH_TCODE_LSB 4
`define ATH_SPD_UNDEF 2'h3
`define ATH_TC_WR_QUAD 4'h0
`define ATH_TC_WR_BLOCK 4'h1
`define ATH_TC_RD_RESP_QUAD 4'h6
`define ATH_TC_RD_RESP_BLOCK 4'h7
`define ATH_TC_LOCK_REQ 4'h9

`define ATH_HDR_LAST_QUAD 2'h2
`define ATH_HDR_LAST_BLOCK 2'h3

`endif

/* rtl/ath_pkg.sv */
// types of the transmit header insertion block
package ath_pkg;

  typedef enum logic [1:0] {
    ATH_IDLE = 2'h0,
    ATH_HDR = 2'h1,
    ATH_DATA = 2'h3
  } ath_state_t;

  typedef enum logic [1:0] {
    ATH_OWN_NONE = 2'h0,
    ATH_OWN_MHP = 2'h1,
    ATH_OWN_FSP = 2'h2
  } ath_owner_t;

endpackage

/* rtl/ath_async_tx_header_insert.sv */
// asynchronous transmit data buffer with per-buffer header insertion
`timescale 1ns/1ps
`include "ath_cfg.svh"

module ath_async_tx_header_insert #(
  parameter int NBUF = `ATH_NUM_BUF,
  parameter int WORDS = `ATH_DB_WORDS
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // micro host port
  input wire logic mhpWrEn,
  input wire logic mhpRdEn,
  input wire logic [$clog2(NBUF)-1:0] mhpBuf,
  input wire logic [2:0] mhpSel,
  input wire logic [31:0] mhpWrData,
  output logic [31:0] mhpRdData,
  // fast stream port
  input wire logic fspValid,
  output logic fspReady,
  input wire logic [$clog2(NBUF)-1:0] fspBuf,
  input wire logic [31:0] fspData,
  input wire logic fspLast,
  // transmit side
  output logic txValid,
  input wire logic txReady,
  output logic [31:0] txData,
  output logic txLast,
  output logic [$clog2(NBUF)-1:0] txBuf,
  output logic txSpdUndef
);

  localparam int BW = $clog2(NBUF);
  localparam int PDEP = WORDS / NBUF;
  localparam int PW = $clog2(PDEP);
  localparam int AW = $clog2(WORDS);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(PDEP);

  // shared buffer; bit 32 marks the final quadlet of a packet
  logic [32:0] mem [WORDS];

  logic [31:0] hdr_r [NBUF][4];
  logic [PW-1:0] wrPtr_r [NBUF];
  logic [PW-1:0] wrPtr_nxt [NBUF];
  logic [PW-1:0] rdPtr_r [NBUF];
  logic [PW-1:0] rdPtr_nxt [NBUF];
  logic [PW:0] count_r [NBUF];
  logic [PW:0] count_nxt [NBUF];
  logic [PW:0] pktCnt_r [NBUF];
  logic [PW:0] pktCnt_nxt [NBUF];
  ath_pkg::ath_owner_t owner_r [NBUF];
  ath_pkg::ath_owner_t owner_nxt [NBUF];
  logic [NBUF-1:0] insEn_r;
  logic [NBUF-1:0] dropped_r;
  logic [NBUF-1:0] dropped_nxt;
  logic [31:0] mhpRdData_r;

  ath_pkg::ath_state_t state_r;
  logic [BW-1:0] curBuf_r;
  logic [1:0] hdrIdx_r;
  logic [1:0] lastHdr_r;
  logic spdUndef_r;
  logic txValid_r;
  logic txLast_r;
  logic [31:0] txData_r;

  // write side decode
  wire mhpAccSel = (mhpSel == `ATH_SEL_ACC0) || (mhpSel == `ATH_SEL_ACC1);
  wire mhpAcc = mhpWrEn && mhpAccSel;
  wire mhpFinal = mhpSel == `ATH_SEL_ACC1;
  wire mhpConflict = owner_r[mhpBuf] == ath_pkg::ATH_OWN_FSP;
  wire mhpFull = count_r[mhpBuf] == FULL_CNT;
  wire mhpPush = mhpAcc && !mhpConflict && !mhpFull;
  wire mhpDrop = mhpAcc && !mhpPush;
  wire fspBlocked = owner_r[fspBuf] == ath_pkg::ATH_OWN_MHP;
  wire fspFull = count_r[fspBuf] == FULL_CNT;
  wire fspPush = fspValid && fspReady;
  wire push = mhpPush || fspPush;
  wire [BW-1:0] wrBuf = mhpPush ? mhpBuf : fspBuf;
  wire [31:0] wrData = mhpPush ? mhpWrData : fspData;
  wire wrEnd = mhpPush ? mhpFinal : fspLast;
  wire [AW-1:0] wrAddr = AW'({wrBuf, wrPtr_r[wrBuf]});
  wire hdrSel = (mhpSel >= `ATH_SEL_H0) && (mhpSel <= `ATH_SEL_H3);
  wire hdrWr = mhpWrEn && hdrSel;
  wire [1:0] hdrWrIdx = 2'(mhpSel - `ATH_SEL_H0);
  wire ctrlWr = mhpWrEn && (mhpSel == `ATH_SEL_CTRL);
  wire statWr = mhpWrEn && (mhpSel == `ATH_SEL_STAT);

  // micro host data writes (selects 0 and 1) take the buffer cycle, so the stream waits
  assign fspReady = !mhpAcc && !fspBlocked && !fspFull;

  // transmit side decode
  wire slotFree = !txValid_r || txReady;
  wire [AW-1:0] rdAddr = AW'({curBuf_r, rdPtr_r[curBuf_r]});
  wire [32:0] rdWord = mem[rdAddr];
  wire pop = (state_r == ath_pkg::ATH_DATA) && slotFree;
  wire popEnd = pop && rdWord[32];

  logic anyPend;
  logic [BW-1:0] pickBuf;
  always_comb begin
    anyPend = 1'b0;
    pickBuf = '0;
    for (int i = NBUF - 1; i >= 0; i--) begin
      if (pktCnt_r[i] != '0) begin
        anyPend = 1'b1;
        pickBuf = BW'(i);
      end
    end
  end

  wire [31:0] pickH0 = hdr_r[pickBuf][0];
  wire [3:0] pickTc = pickH0[`ATH_TCODE_LSB +: 4];
  wire tcBlock = (pickTc == `ATH_TC_WR_BLOCK) || (pickTc == `ATH_TC_RD_RESP_BLOCK) ||
                 (pickTc == `ATH_TC_LOCK_REQ);
  wire tcQuad = (pickTc == `ATH_TC_WR_QUAD) || (pickTc == `ATH_TC_RD_RESP_QUAD);
  wire tcInsertable = tcBlock || tcQuad;
  wire doInsert = insEn_r[pickBuf] && tcInsertable;
  wire pickSpdUndef = pickH0[`ATH_SPD_LSB +: 2] == `ATH_SPD_UNDEF;

  // per-buffer pointer, fill and ownership bookkeeping
  always_comb begin
    for (int i = 0; i < NBUF; i++) begin
      logic wrHit;
      logic rdHit;
      wrHit = push && (wrBuf == BW'(i));
      rdHit = pop && (curBuf_r == BW'(i));
      wrPtr_nxt[i] = wrHit ? wrPtr_r[i] + 1'b1 : wrPtr_r[i];
      rdPtr_nxt[i] = rdHit ? rdPtr_r[i] + 1'b1 : rdPtr_r[i];
      count_nxt[i] = count_r[i] + (PW+1)'(wrHit) - (PW+1)'(rdHit);
      pktCnt_nxt[i] = pktCnt_r[i] + (PW+1)'(wrHit && wrEnd) - (PW+1)'(rdHit && rdWord[32]);
      owner_nxt[i] = owner_r[i];
      if (wrHit) begin
        owner_nxt[i] = wrEnd ? ath_pkg::ATH_OWN_NONE : (mhpPush ? ath_pkg::ATH_OWN_MHP : ath_pkg::ATH_OWN_FSP);
      end
      // a drop in the same cycle as the clear stays visible
      dropped_nxt[i] = (dropped_r[i] && !(statWr && mhpBuf == BW'(i) && mhpWrData[`ATH_STAT_DROP_BIT])) ||
                       (mhpDrop && mhpBuf == BW'(i));
    end
  end

  // register read mux
  logic [31:0] rdMux;
  always_comb begin
    rdMux = '0;
    if (hdrSel) begin
      rdMux = hdr_r[mhpBuf][hdrWrIdx];
    end else if (mhpSel == `ATH_SEL_CTRL) begin
      rdMux = 32'(insEn_r[mhpBuf]);
    end else if (mhpSel == `ATH_SEL_STAT) begin
      rdMux[`ATH_STAT_DROP_BIT] = dropped_r[mhpBuf];
      rdMux[29:28] = owner_r[mhpBuf];
      rdMux[27:16] = 12'(pktCnt_r[mhpBuf]);
      rdMux[11:0] = 12'(count_r[mhpBuf]);
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrAddr] <= {wrEnd, wrData};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < NBUF; i++) begin
        for (int j = 0; j < 4; j++) begin
          hdr_r[i][j] <= `ATH_HDR_RESET;
        end
      end
    end else if (hdrWr) begin
      hdr_r[mhpBuf][hdrWrIdx] <= mhpWrData;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      for (int i = 0; i < NBUF; i++) begin
        wrPtr_r[i] <= '0;
        rdPtr_r[i] <= '0;
        count_r[i] <= '0;
        pktCnt_r[i] <= '0;
        owner_r[i] <= ath_pkg::ATH_OWN_NONE;
      end
      dropped_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
      pktCnt_r <= pktCnt_nxt;
      owner_r <= owner_nxt;
      dropped_r <= dropped_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      insEn_r <= '0;
    end else if (ctrlWr) begin
      insEn_r[mhpBuf] <= mhpWrData[`ATH_CTRL_INS_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mhpRdData_r <= '0;
    end else if (mhpRdEn) begin
      mhpRdData_r <= rdMux;
    end
  end

  // transmit sequencer: optional headers, then payload to the end marker
  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= ath_pkg::ATH_IDLE;
      curBuf_r <= '0;
      hdrIdx_r <= '0;
      lastHdr_r <= `ATH_HDR_LAST_QUAD;
      spdUndef_r <= 1'b0;
      txValid_r <= 1'b0;
      txLast_r <= 1'b0;
      txData_r <= '0;
    end else begin
      if (txReady) begin
        txValid_r <= 1'b0;
      end
      unique case (state_r)
        ath_pkg::ATH_IDLE: begin
          // pick only once the last word is leaving, so txBuf holds and one idle cycle follows
          if (anyPend && slotFree) begin
            curBuf_r <= pickBuf;
            hdrIdx_r <= '0;
            lastHdr_r <= tcBlock ? `ATH_HDR_LAST_BLOCK : `ATH_HDR_LAST_QUAD;
            spdUndef_r <= doInsert && pickSpdUndef;
            state_r <= doInsert ? ath_pkg::ATH_HDR : ath_pkg::ATH_DATA;
          end
        end
        ath_pkg::ATH_HDR: begin
          if (slotFree) begin
            txData_r <= hdr_r[curBuf_r][hdrIdx_r];
            txValid_r <= 1'b1;
            txLast_r <= 1'b0;
            hdrIdx_r <= hdrIdx_r + 1'b1;
            if (hdrIdx_r == lastHdr_r) begin
              state_r <= ath_pkg::ATH_DATA;
            end
          end
        end
        ath_pkg::ATH_DATA: begin
          if (slotFree) begin
            txData_r <= rdWord[31:0];
            txValid_r <= 1'b1;
            txLast_r <= rdWord[32];
            if (popEnd) begin
              state_r <= ath_pkg::ATH_IDLE;
            end
          end
        end
        default: begin
          state_r <= ath_pkg::ATH_IDLE;
        end
      endcase
    end
  end

  assign mhpRdData = mhpRdData_r;
  assign txValid = txValid_r;
  assign txData = txData_r;
  assign txLast = txLast_r;
  assign txBuf = curBuf_r;
  assign txSpdUndef = spdUndef_r;

endmodule

/* bench/ath_tx_monitor.sv */
// port assertions of the header insertion block
`timescale 1ns/1ps
module ath_tx_monitor #(
  parameter int NBUF = 8
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // micro and stream side
  input wire logic mhpWrEn,
  input wire logic mhpRdEn,
  input wire logic [2:0] mhpSel,
  input wire logic [31:0] mhpRdData,
  input wire logic fspReady,
  // transmit side
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [31:0] txData,
  input wire logic txLast,
  input wire logic [$clog2(NBUF)-1:0] txBuf,
  input wire logic txSpdUndef
);
  AST_RST_TX: assert property (@(posedge clock) reset |=> !txValid && txData == 32'h0 && !txLast)
    else $error("tx not cleared by reset");
  AST_RST_RD: assert property (@(posedge clock) reset |=> mhpRdData == 32'h0)
    else $error("read data not cleared by reset");
  AST_RST_RDY: assert property (@(posedge clock) reset ##1 (reset && !mhpWrEn) |-> fspReady)
    else $error("stream port not ready in reset");
  AST_TX_HOLD: assert property (@(posedge clock) disable iff (reset)
    txValid && !txReady |=> txValid && $stable(txData) && $stable(txLast)) else $error("tx word not held");
  AST_BUF_HOLD: assert property (@(posedge clock) disable iff (reset)
    txValid && !txReady |=> $stable(txBuf) && $stable(txSpdUndef)) else $error("tx buffer or flag moved");
  AST_GAP: assert property (@(posedge clock) disable iff (reset) txValid && txReady && txLast |=> !txValid)
    else $error("no idle after packet");
  AST_FSP_BLK: assert property (@(posedge clock) disable iff (reset) mhpWrEn && mhpSel < 3'h2 |-> !fspReady)
    else $error("stream taken during micro write");
  AST_RD_HOLD: assert property (@(posedge clock) disable iff (reset) !mhpRdEn |=> $stable(mhpRdData))
    else $error("read data moved");
  cover property (@(posedge clock) txValid && txReady && txLast);
  cover property (@(posedge clock) txValid && !txReady);
  cover property (@(posedge clock) mhpWrEn && !fspReady);
endmodule
bind ath_async_tx_header_insert ath_tx_monitor #(.NBUF(NBUF)) u_ath_tx_monitor (.clock(clock), .reset(reset),
  .mhpWrEn(mhpWrEn), .mhpRdEn(mhpRdEn), .mhpSel(mhpSel), .mhpRdData(mhpRdData), .fspReady(fspReady),
  .txValid(txValid), .txReady(txReady), .txData(txData), .txLast(txLast), .txBuf(txBuf), .txSpdUndef(txSpdUndef));

/* bench/ath_fsp_writer.sv */
// stream writer model on the fast stream port
`timescale 1ns/1ps
module ath_fsp_writer (
  // clock
  input wire logic clock,
  // fast stream port
  output logic fspValid,
  input wire logic fspReady,
  output logic [2:0] fspBuf,
  output logic [31:0] fspData,
  output logic fspLast
);
  logic sendTimeout = 1'b0;
  initial begin
    fspValid = 1'b0;
    fspBuf = 3'h0;
    fspData = 32'h0;
    fspLast = 1'b0;
  end
  // whole packet on this port, header and priority left to the payload
  task automatic send(logic [2:0] b, int n);
    int k;
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      fspValid = 1'b1;
      fspBuf = b;
      fspData = 32'hd0000001 + i;
      fspLast = (i == n - 1);
      for (k = 0; k < 50; k++) begin
        @(posedge clock);
        if (fspReady === 1'b1) break;
      end
      if (k == 50) sendTimeout = 1'b1;
    end
    @(negedge clock);
    fspValid = 1'b0;
    fspData = ~fspData;
  endtask
endmodule

/* bench/ath_async_tx_header_insert_bench.sv */
// self-checking bench of the header insertion block
`timescale 1ns/1ps
module ath_async_tx_header_insert_bench;
  typedef struct {logic [31:0] h0; int nh; logic su;} ath_row_t;
  logic clock = 1'b0, reset = 1'b1, mhpWrEn = 1'b0, mhpRdEn = 1'b0, txReady = 1'b0;
  logic [2:0] mhpBuf = 3'h0, mhpSel = 3'h0, txBuf, fspBuf;
  logic [31:0] mhpWrData = 32'h0, mhpRdData, txData, fspData;
  logic fspValid, fspReady, fspLast, txValid, txLast, txSpdUndef;
  int error_cnt = 0, checks_done = 0;
  ath_row_t rows [6] = '{'{32'h00000000, 3, 1'b0}, '{32'h00010010, 4, 1'b0}, '{32'h00020060, 3, 1'b0},
    '{32'h00000070, 4, 1'b0}, '{32'h00030090, 4, 1'b1}, '{32'h00000040, 0, 1'b0}};
  always #4 clock = ~clock;
  ath_async_tx_header_insert u_ath_async_tx_header_insert (.clock(clock), .reset(reset), .mhpWrEn(mhpWrEn),
    .mhpRdEn(mhpRdEn), .mhpBuf(mhpBuf), .mhpSel(mhpSel), .mhpWrData(mhpWrData), .mhpRdData(mhpRdData),
    .fspValid(fspValid), .fspReady(fspReady), .fspBuf(fspBuf), .fspData(fspData), .fspLast(fspLast),
    .txValid(txValid), .txReady(txReady), .txData(txData), .txLast(txLast), .txBuf(txBuf), .txSpdUndef(txSpdUndef));
  ath_fsp_writer u_ath_fsp_writer (.clock(clock), .fspValid(fspValid), .fspReady(fspReady), .fspBuf(fspBuf),
    .fspData(fspData), .fspLast(fspLast));
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // write strobe stays up across back-to-back writes
  task automatic mw(logic [2:0] b, logic [2:0] s, logic [31:0] d);
    mhpBuf = b;
    mhpSel = s;
    mhpWrData = d;
    mhpWrEn = 1'b1;
    @(negedge clock);
  endtask
  task automatic mr(logic [2:0] b, logic [2:0] s, logic [31:0] e);
    mhpBuf = b;
    mhpSel = s;
    mhpRdEn = 1'b1;
    @(negedge clock);
    mhpRdEn = 1'b0;
    @(negedge clock);
    chk("mhpRdData", e, mhpRdData);
  endtask
  // one word taken at the first falling edge that sees txValid, so only a word already waiting sees a stall cycle
  task automatic rx(logic [31:0] e, logic l, logic [2:0] b, logic su);
    int k;
    @(negedge clock);
    for (k = 0; k < 60 && txValid !== 1'b1; k++) @(negedge clock);
    if (k == 60) begin
      error_cnt++;
      wrap_up();
    end
    chk("txData", e, txData);
    chk("txLast", {31'h0, l}, {31'h0, txLast});
    chk("txBuf", {29'h0, b}, {29'h0, txBuf});
    chk("txSpdUndef", {31'h0, su}, {31'h0, txSpdUndef});
    txReady = 1'b1;
    @(negedge clock);
    txReady = 1'b0;
  endtask
  task automatic pkt(logic [2:0] b, logic [31:0] h0, int nh, logic su);
    for (int i = 0; i < nh; i++) rx(i == 0 ? h0 : 32'haaaa0000 | i, 1'b0, b, su);
    rx(32'hd0000001, 1'b0, b, su);
    rx(32'hd0000002, 1'b1, b, su);
  endtask
  initial begin
    repeat (3) @(negedge clock);
    reset = 1'b0;
    for (int s = 2; s < 7; s++) mr(3'h1, 3'(s), 32'h0);
    for (int r = 0; r < 6; r++) begin
      mw(3'h0, 3'h2, rows[r].h0);
      for (int s = 1; s < 4; s++) mw(3'h0, 3'(s + 2), 32'haaaa0000 | s);
      mw(3'h0, 3'h6, 32'h1);
      mw(3'h0, 3'h0, 32'hd0000001);
      mw(3'h0, 3'h1, 32'hd0000002);
      mhpWrEn = 1'b0;
      pkt(3'h0, rows[r].h0, rows[r].nh, rows[r].su);
    end
    mr(3'h0, 3'h2, rows[5].h0);
    mw(3'h2, 3'h0, 32'hd0000001);
    mw(3'h2, 3'h1, 32'hd0000002);
    mhpWrEn = 1'b0;
    pkt(3'h2, 32'h0, 0, 1'b0);
    fork
      u_ath_fsp_writer.send(3'h3, 2);
      begin
        mw(3'h1, 3'h0, 32'hd0000001);
        mw(3'h1, 3'h1, 32'hd0000002);
        mhpWrEn = 1'b0;
      end
    join
    chk("fspTimeout", 32'h0, {31'h0, u_ath_fsp_writer.sendTimeout});
    pkt(3'h1, 32'h0, 0, 1'b0);
    pkt(3'h3, 32'h0, 0, 1'b0);
    // fill one partition past its size: the extra word is dropped and flagged
    for (int i = 0; i < 257; i++) mw(3'h4, 3'h0, 32'h1);
    mhpWrEn = 1'b0;
    mr(3'h4, 3'h7, 32'h90000100);
    mw(3'h4, 3'h7, 32'h80000000);
    mhpWrEn = 1'b0;
    mr(3'h4, 3'h7, 32'h10000100);
    reset = 1'b1;
    repeat (3) @(negedge clock);
    reset = 1'b0;
    mr(3'h0, 3'h2, 32'h0);
    mr(3'h4, 3'h7, 32'h0);
    wrap_up();
  end
endmodule
